// *** display_ctl_pkg.sv ***
// constants shared by the display controller start/stop logic
// assumes a single 10 MHz clock and a 32-bit register bus
`default_nettype none
package display_ctl_pkg;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int MS_NS = 1000000;
  localparam int CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;
  localparam int FRAME_MIN_MS = 19;
  localparam int FRAME_MAX_MS = 21;
  localparam int FRAME_MS = (FRAME_MIN_MS + FRAME_MAX_MS) / 2;
  // ************************************************************
  // register map and fields
  // ************************************************************
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_MASK = 8'h04;
  localparam logic [7:0] OFF_STATE = 8'h08;
  localparam logic [7:0] OFF_IE = 8'h0c;
  localparam int EV_EOF = 0;
  localparam int EV_STOP = 1;
  localparam int EV_REJECT = 2;
  localparam int EV_W = 3;
  localparam logic [EV_W-1:0] MASK_RST = 3'h0;
  localparam int ST_RUN_BIT = 16;
  localparam int ST_STOP_PEND_BIT = 17;
  localparam int ST_HOST_IRQ_BIT = 18;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ************************************************************
  // host side
  // ************************************************************
  localparam int DW = 16;
  localparam logic [DW-1:0] IE_RST = 16'h0000;
  localparam logic [DW-1:0] P_RST = 16'h0000;
  localparam int IE_EOF_BIT = 0;
  localparam logic [3:0] SP_FIRST = 4'h1;
  localparam int OP_HI = 15;
  localparam int OP_LO = 12;
  localparam int TGT_W = 12;
  localparam logic [3:0] OP_JUMP = 4'h1;
  localparam logic [3:0] OP_EOF = 4'h2;
  typedef enum logic [3:0] {
    CMD_RESET = 4'h0,
    CMD_START = 4'h1,
    CMD_FINISH = 4'h2,
    CMD_LOAD_IE = 4'h3,
    CMD_READ_IE = 4'h4,
    CMD_LOAD_ID = 4'h5,
    CMD_LOAD_P = 4'h6,
    CMD_UNLOAD_P = 4'h7,
    CMD_LOAD_SP = 4'h8,
    CMD_UNLOAD_SP = 4'h9
  } cmd_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_FETCH = 2'h1,
    ST_FRAME = 2'h2
  } run_t;
endpackage
`default_nettype wire

// *** frame_timer.sv ***
// frame pacing timer: a millisecond enable divider and a frame count
// assumes restart is a one-cycle pulse from the controller
`default_nettype none
module frame_timer #(
  parameter int CYCLES_PER_MS = display_ctl_pkg::CYCLES_PER_MS,
  parameter int FRAME_MS = display_ctl_pkg::FRAME_MS
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic restart,
  // status
  output logic done
);
  // the divider and frame counters are 16 and 8 bits wide
  if (CYCLES_PER_MS < 1 || CYCLES_PER_MS > 65535 || FRAME_MS < 1 || FRAME_MS > 255)
  begin : g_bad_params
    $error("frame_timer parameters out of range");
  end
  typedef struct packed {
    logic [15:0] div;
    logic [7:0] ms;
    logic done;
  } tmr_t;
  tmr_t q, d;
  logic tick;
  // ************************************************************
  // divider and frame count
  // ************************************************************
  always_comb
  begin
    d = q;
    tick = (q.div == 16'(CYCLES_PER_MS - 1));
    d.div = tick ? 16'h0000 : q.div + 16'h0001;
    if (tick && !q.done)
    begin
      d.ms = q.ms + 8'h01;
      if (q.ms == 8'(FRAME_MS - 1))
        d.done = 1'b1;
    end
    // restart realigns the divider so a frame is a whole count
    if (restart)
    begin
      d.div = 16'h0000;
      d.ms = 8'h00;
      d.done = 1'b0;
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      q <= '0;
    else
      q <= d;
  end
  assign done = q.done;
endmodule // frame_timer
`default_nettype wire

// *** display_control.sv ***
// display controller start/stop and host command handling
// assumes the host waits for a reply or reject before its next command,
// a display memory that answers mem_req with mem_ack, and AXI4-Lite access
//
// Functional notes
// - reset command replies and clears interrupt enable to zero
// - idle write of interrupt enable replies and reads back unchanged
// - idle load and unload of program counter reply and read back
// - start replies and begins fetching at the program counter
// - jump instruction loads program counter, self-jump loops forever
// - running host write of scratchpad 0F-01 is externally rejected
// - running host read of scratchpad 0F-01 is externally rejected
// - reset while running replies, stops, scratchpad reads then reply
// - running write of interrupt enable is externally rejected
// - running write of interrupt disable is externally rejected
// - finish replies, completes current instruction, halts, enable writes accepted
// - end-of-frame instruction is recognised and acted on while running
// - enabled end-of-frame interrupt raised about 20 ms after start
`default_nettype none
module display_control #(
  parameter int CYCLES_PER_MS = display_ctl_pkg::CYCLES_PER_MS,
  parameter int FRAME_MS = display_ctl_pkg::FRAME_MS
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // host channel commands
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_code,
  input wire logic [3:0] cmd_reg,
  input wire logic [15:0] cmd_wdata,
  // host channel answers
  output logic cmd_reply,
  output logic cmd_reject,
  output logic [15:0] cmd_rdata,
  output logic host_irq,
  // display memory
  output logic mem_req,
  output logic [15:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [15:0] mem_data,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // interrupt
  output logic irq
);
  if (CYCLES_PER_MS < 1 || CYCLES_PER_MS > 65535 || FRAME_MS < 1 || FRAME_MS > 255)
  begin : g_bad_params
    $error("display_control parameters out of range");
  end

  localparam int EW = display_ctl_pkg::EV_W;

  typedef struct packed {
    display_ctl_pkg::run_t st;
    logic [15:0] p;
    logic [15:0] ie;
    logic [15:1][15:0] sp;
    logic stop_pend;
    logic host_irq;
    logic reply;
    logic reject;
    logic [15:0] hdata;
    logic [EW-1:0] status;
    logic [EW-1:0] mask;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } ctl_t;

  ctl_t q, d;
  logic running;
  logic frame_restart;
  logic frame_done;
  logic [EW-1:0] ev;
  logic wr_go;
  logic rd_go;
  logic [3:0] op;

  // ************************************************************
  // address decode
  // ************************************************************
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == display_ctl_pkg::OFF_STATUS) || (a == display_ctl_pkg::OFF_MASK) ||
             (a == display_ctl_pkg::OFF_STATE) || (a == display_ctl_pkg::OFF_IE);
  endfunction

  function automatic logic is_scratch(input logic [3:0] r);
    is_scratch = (r >= display_ctl_pkg::SP_FIRST);
  endfunction

  frame_timer #(
    .CYCLES_PER_MS(CYCLES_PER_MS),
    .FRAME_MS(FRAME_MS)
  ) u_frame (
    .aclk(aclk),
    .aresetn(aresetn),
    .restart(frame_restart),
    .done(frame_done)
  );

  assign running = (q.st != display_ctl_pkg::ST_IDLE);
  assign op = mem_data[display_ctl_pkg::OP_HI:display_ctl_pkg::OP_LO];
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !q.bvalid;
  assign rd_go = s_axi_arvalid && !q.rvalid;

  always_comb
  begin
    d = q;
    ev = '0;
    frame_restart = 1'b0;
    d.reply = 1'b0;
    d.reject = 1'b0;

    // ************************************************************
    // display instruction engine
    // ************************************************************
    case (q.st)
      display_ctl_pkg::ST_IDLE:
      begin
        d.stop_pend = 1'b0;
      end
      display_ctl_pkg::ST_FETCH:
      begin
        if (mem_ack)
        begin
          case (op)
            display_ctl_pkg::OP_JUMP:
            begin
              // a jump to its own address keeps the engine looping
              d.p = 16'(mem_data[display_ctl_pkg::TGT_W-1:0]);
            end
            display_ctl_pkg::OP_EOF:
            begin
              d.p = q.p + 16'h0001;
              d.st = display_ctl_pkg::ST_FRAME;
            end
            default:
            begin
              d.p = q.p + 16'h0001;
            end
          endcase
          if (q.stop_pend)
          begin
            d.st = display_ctl_pkg::ST_IDLE;
            ev[display_ctl_pkg::EV_STOP] = 1'b1;
          end
        end
      end
      display_ctl_pkg::ST_FRAME:
      begin
        // frame end is paced by the timer, not by the instruction stream
        if (frame_done)
        begin
          frame_restart = 1'b1;
          ev[display_ctl_pkg::EV_EOF] = 1'b1;
          if (q.ie[display_ctl_pkg::IE_EOF_BIT])
            d.host_irq = 1'b1;
          d.st = display_ctl_pkg::ST_FETCH;
          if (q.stop_pend)
          begin
            d.st = display_ctl_pkg::ST_IDLE;
            ev[display_ctl_pkg::EV_STOP] = 1'b1;
          end
        end
      end
      default:
      begin
        d.st = display_ctl_pkg::ST_IDLE;
      end
    endcase

    // ************************************************************
    // host commands, one answer each
    // ************************************************************
    if (cmd_valid)
    begin
      d.reply = 1'b1;
      case (cmd_code)
        display_ctl_pkg::CMD_RESET:
        begin
          d.ie = display_ctl_pkg::IE_RST;
          d.host_irq = 1'b0;
          d.stop_pend = 1'b0;
          if (running)
            ev[display_ctl_pkg::EV_STOP] = 1'b1;
          d.st = display_ctl_pkg::ST_IDLE;
        end
        display_ctl_pkg::CMD_START:
        begin
          if (!running)
          begin
            d.st = display_ctl_pkg::ST_FETCH;
            frame_restart = 1'b1;
          end
        end
        display_ctl_pkg::CMD_FINISH:
        begin
          if (running)
            d.stop_pend = 1'b1;
        end
        display_ctl_pkg::CMD_LOAD_IE:
        begin
          if (running)
          begin
            d.reply = 1'b0;
            d.reject = 1'b1;
          end
          else
          begin
            d.ie = cmd_wdata;
            d.host_irq = 1'b0;
          end
        end
        display_ctl_pkg::CMD_LOAD_ID:
        begin
          if (running)
          begin
            d.reply = 1'b0;
            d.reject = 1'b1;
          end
          else
          begin
            d.ie = q.ie & ~cmd_wdata;
            d.host_irq = 1'b0;
          end
        end
        display_ctl_pkg::CMD_READ_IE:
        begin
          d.hdata = q.ie;
        end
        display_ctl_pkg::CMD_LOAD_P:
        begin
          if (running)
          begin
            d.reply = 1'b0;
            d.reject = 1'b1;
          end
          else
            d.p = cmd_wdata;
        end
        display_ctl_pkg::CMD_UNLOAD_P:
        begin
          d.hdata = q.p;
        end
        display_ctl_pkg::CMD_LOAD_SP:
        begin
          if (running || !is_scratch(cmd_reg))
          begin
            d.reply = 1'b0;
            d.reject = 1'b1;
          end
          else
            d.sp[cmd_reg] = cmd_wdata;
        end
        display_ctl_pkg::CMD_UNLOAD_SP:
        begin
          if (running || !is_scratch(cmd_reg))
          begin
            d.reply = 1'b0;
            d.reject = 1'b1;
          end
          else
            d.hdata = q.sp[cmd_reg];
        end
        default:
        begin
          d.reply = 1'b0;
          d.reject = 1'b1;
        end
      endcase
      if (d.reject)
        ev[display_ctl_pkg::EV_REJECT] = 1'b1;
    end

    // ************************************************************
    // register bus slave
    // ************************************************************
    if (q.bvalid && s_axi_bready)
      d.bvalid = 1'b0;
    if (wr_go)
    begin
      d.bvalid = 1'b1;
      d.bresp = mapped(s_axi_awaddr) ? display_ctl_pkg::RESP_OKAY
                                     : display_ctl_pkg::RESP_SLVERR;
      if (s_axi_awaddr == display_ctl_pkg::OFF_MASK && s_axi_wstrb[0])
        d.mask = s_axi_wdata[EW-1:0];
    end
    if (q.rvalid && s_axi_rready)
      d.rvalid = 1'b0;
    if (rd_go)
    begin
      d.rvalid = 1'b1;
      d.rresp = display_ctl_pkg::RESP_OKAY;
      d.rdata = 32'h00000000;
      case (s_axi_araddr)
        display_ctl_pkg::OFF_STATUS:
        begin
          d.rdata[EW-1:0] = q.status;
          d.status = '0;
        end
        display_ctl_pkg::OFF_MASK:
          d.rdata[EW-1:0] = q.mask;
        display_ctl_pkg::OFF_STATE:
        begin
          d.rdata[15:0] = q.p;
          d.rdata[display_ctl_pkg::ST_RUN_BIT] = running;
          d.rdata[display_ctl_pkg::ST_STOP_PEND_BIT] = q.stop_pend;
          d.rdata[display_ctl_pkg::ST_HOST_IRQ_BIT] = q.host_irq;
        end
        display_ctl_pkg::OFF_IE:
          d.rdata[15:0] = q.ie;
        default:
          d.rresp = display_ctl_pkg::RESP_SLVERR;
      endcase
    end
    // a new event wins over the clear of a status read
    d.status = d.status | ev;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q <= '0;
      q.st <= display_ctl_pkg::ST_IDLE;
      q.p <= display_ctl_pkg::P_RST;
      q.ie <= display_ctl_pkg::IE_RST;
      q.mask <= display_ctl_pkg::MASK_RST;
    end
    else
      q <= d;
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign cmd_reply = q.reply;
  assign cmd_reject = q.reject;
  assign cmd_rdata = q.hdata;
  assign host_irq = q.host_irq;
  assign mem_req = (q.st == display_ctl_pkg::ST_FETCH);
  assign mem_addr = q.p;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = rd_go;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rdata = q.rdata;
  assign irq = |(q.status & q.mask);
endmodule // display_control
`default_nettype wire

// *** display_ctl_sva.sv ***
// checker for the display controller host channel and fetch engine
// bound to display_control; watches its ports only
`default_nettype none
module display_ctl_sva (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // host channel
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_code,
  input wire logic cmd_reply,
  input wire logic cmd_reject,
  input wire logic [15:0] cmd_rdata,
  input wire logic host_irq,
  // display memory
  input wire logic mem_req,
  input wire logic [15:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [15:0] mem_data
);
  // ********************
  // properties
  // ********************
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic rst_c, sp_c, wr_c, fetch, jmp;
  assign rst_c = cmd_valid && cmd_code == display_ctl_pkg::CMD_RESET;
  assign sp_c = cmd_valid && cmd_code inside {display_ctl_pkg::CMD_LOAD_SP,
    display_ctl_pkg::CMD_UNLOAD_SP};
  assign wr_c = cmd_valid && cmd_code inside {display_ctl_pkg::CMD_LOAD_IE,
    display_ctl_pkg::CMD_LOAD_ID};
  // a host command in the same cycle may stop the engine, so leave it out
  assign fetch = mem_req && mem_ack && !cmd_valid;
  assign jmp = mem_data[15:12] == display_ctl_pkg::OP_JUMP;
  a_one_answer: assert property (cmd_valid |=> cmd_reply != cmd_reject)
    else $error("command not answered exactly once");
  a_no_extra: assert property (!cmd_valid |=> !cmd_reply && !cmd_reject)
    else $error("answer without command");
  a_reset_stop: assert property (rst_c |=> cmd_reply && !mem_req && !host_irq)
    else $error("reset command not replied or engine not stopped");
  a_run_scratch: assert property (sp_c && mem_req |=> cmd_reject)
    else $error("scratch access accepted while running");
  a_run_enable: assert property (wr_c && mem_req |=> cmd_reject)
    else $error("interrupt register write accepted while running");
  a_jump_load: assert property (fetch && jmp |=> mem_addr == {4'h0, $past(mem_data[11:0])})
    else $error("jump target not loaded");
  a_step_next: assert property (fetch && !jmp |=> mem_addr == $past(mem_addr) + 16'h1)
    else $error("fetch address not advanced");
  a_fetch_hold: assert property (mem_req && !mem_ack && !cmd_valid |=> mem_req && $stable(mem_addr))
    else $error("fetch dropped before answer");
  a_rdata_hold: assert property (!cmd_valid |=> $stable(cmd_rdata))
    else $error("read data changed without command");
endmodule // display_ctl_sva
`default_nettype wire

// *** disp_mem.sv ***
// display memory model answering fetches after one or four cycles
// assumes mem_req holds its address until mem_ack is seen
`default_nettype none
module disp_mem (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // fetch port
  input wire logic mem_req,
  input wire logic [15:0] mem_addr,
  output logic mem_ack,
  output logic [15:0] mem_data,
  // pacing
  input wire logic slow
);
  timeunit 1ns;
  timeprecision 1ns;
  // ********************
  // program store
  // ********************
  logic [2:0] cnt;
  function automatic logic [15:0] word(input logic [15:0] a);
    case (a)
      16'h0010: word = 16'h1010;
      16'h0020: word = 16'h2000;
      16'h0021: word = 16'h1021;
      default: word = 16'h0000;
    endcase
  endfunction
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt <= 3'h0;
      mem_ack <= 1'b0;
      mem_data <= 16'hffff;
    end
    else if (mem_ack)
    begin
      mem_ack <= 1'b0;
      mem_data <= ~mem_data;
      cnt <= 3'h0;
    end
    else if (mem_req && cnt == (slow ? 3'h3 : 3'h0))
    begin
      mem_ack <= 1'b1;
      mem_data <= word(mem_addr);
    end
    else
    begin
      // data off the answer cycle toggles so a stale word never passes
      mem_data <= ~mem_data;
      cnt <= mem_req ? cnt + 3'h1 : 3'h0;
    end
  end
endmodule // disp_mem
`default_nettype wire

// *** testbench.sv ***
// bench for display_control: host commands, fetch engine, registers, interrupt
// assumes disp_mem as display memory and display_ctl_sva bound below
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [1:0] OK = 2'h2;
  localparam logic [1:0] REJ = 2'h1;
  logic aclk, aresetn, cv, rep, rej, hirq, mreq, mack, slow, irq;
  logic awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
  logic [3:0] cc, cr, wstrb;
  logic [15:0] cw, crd, maddr, mdat;
  logic [7:0] awa, ara;
  logic [31:0] wdata, rdata, rdv;
  logic [1:0] bresp, rresp, rds, bds;
  int error_cnt, tests_run;
  display_control #(.CYCLES_PER_MS(10), .FRAME_MS(20)) dut (.aclk(aclk), .aresetn(aresetn),
    .cmd_valid(cv), .cmd_code(cc), .cmd_reg(cr), .cmd_wdata(cw), .cmd_reply(rep),
    .cmd_reject(rej), .cmd_rdata(crd), .host_irq(hirq), .mem_req(mreq), .mem_addr(maddr),
    .mem_ack(mack), .mem_data(mdat), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .irq(irq));
  disp_mem mem (.aclk(aclk), .aresetn(aresetn), .mem_req(mreq), .mem_addr(maddr),
    .mem_ack(mack), .mem_data(mdat), .slow(slow));
  // ********************
  // helpers
  // ********************
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    if (error_cnt == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task tmo;
    error_cnt++;
    $display("BAD %0t wait ran out", $time);
    report_and_stop();
  endtask
  task host(input logic [3:0] c, input logic [3:0] r, input logic [15:0] w, input logic [1:0] e);
    @(posedge aclk);
    cv <= 1'b1;
    cc <= c;
    cr <= r;
    cw <= w;
    @(posedge aclk);
    cv <= 1'b0;
    @(negedge aclk);
    chk(32'({rep, rej}), 32'(e));
  endtask
  task axw(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    int n;
    @(posedge aclk);
    awa <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    tb = 1'b0;
    for (n = 0; !tb; n++)
    begin
      if (n == 50) tmo();
      @(negedge aclk);
      ta = awr;
      tw = wr;
      tb = bv;
      bds = bresp;
      @(posedge aclk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      if (tb) br <= 1'b0;
    end
  endtask
  task axr(input logic [7:0] a);
    logic ta, tr;
    int n;
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    tr = 1'b0;
    for (n = 0; !tr; n++)
    begin
      if (n == 50) tmo();
      @(negedge aclk);
      ta = arr;
      tr = rv;
      rdv = rdata;
      rds = rresp;
      @(posedge aclk);
      if (ta) arv <= 1'b0;
      if (tr) rr <= 1'b0;
    end
  endtask
  // ********************
  // scenarios
  // ********************
  task t_idle;
    axr(display_ctl_pkg::OFF_IE);
    chk(rdv, 32'h0);
    host(display_ctl_pkg::CMD_RESET, 4'h0, 16'h0, OK);
    host(display_ctl_pkg::CMD_READ_IE, 4'h0, 16'h0, OK);
    chk(32'(crd), 32'h0);
    host(display_ctl_pkg::CMD_LOAD_IE, 4'h0, 16'heecf, OK);
    host(display_ctl_pkg::CMD_READ_IE, 4'h0, 16'h0, OK);
    chk(32'(crd), 32'heecf);
    axr(display_ctl_pkg::OFF_IE);
    chk(rdv, 32'heecf);
    chk(32'(rds), 32'(display_ctl_pkg::RESP_OKAY));
    host(display_ctl_pkg::CMD_LOAD_ID, 4'h0, 16'h000f, OK);
    host(display_ctl_pkg::CMD_READ_IE, 4'h0, 16'h0, OK);
    chk(32'(crd), 32'heec0);
    host(display_ctl_pkg::CMD_LOAD_P, 4'h0, 16'h0010, OK);
    host(display_ctl_pkg::CMD_UNLOAD_P, 4'h0, 16'h0, OK);
    chk(32'(crd), 32'h0010);
    host(display_ctl_pkg::CMD_LOAD_SP, 4'hf, 16'h5a5a, OK);
    host(display_ctl_pkg::CMD_UNLOAD_SP, 4'hf, 16'h0, OK);
    chk(32'(crd), 32'h5a5a);
    axr(8'h10);
    chk(32'(rds), 32'(display_ctl_pkg::RESP_SLVERR));
    axw(8'h10, 32'h0);
    chk(32'(bds), 32'(display_ctl_pkg::RESP_SLVERR));
    host(display_ctl_pkg::CMD_LOAD_SP, 4'h0, 16'h1234, REJ);
    host(4'ha, 4'h0, 16'h0, REJ);
  endtask
  task t_run;
    logic [3:0] i;
    @(posedge aclk);
    slow <= 1'b1;
    host(display_ctl_pkg::CMD_START, 4'h0, 16'h0, OK);
    repeat (20) @(posedge aclk);
    axr(display_ctl_pkg::OFF_STATE);
    chk(32'(rdv[16:0]), 32'h10010);
    for (i = 4'hf; i != 4'h0; i--)
    begin
      host(display_ctl_pkg::CMD_LOAD_SP, i, 16'h1234, REJ);
      host(display_ctl_pkg::CMD_UNLOAD_SP, i, 16'h0, REJ);
    end
    host(display_ctl_pkg::CMD_LOAD_IE, 4'h0, 16'heecf, REJ);
    host(display_ctl_pkg::CMD_LOAD_ID, 4'h0, 16'hffff, REJ);
    host(display_ctl_pkg::CMD_LOAD_P, 4'h0, 16'h0020, REJ);
    host(display_ctl_pkg::CMD_RESET, 4'h0, 16'h0, OK);
    for (i = 4'hf; i != 4'h0; i--)
      host(display_ctl_pkg::CMD_UNLOAD_SP, i, 16'h0, OK);
    @(posedge aclk);
    slow <= 1'b0;
  endtask
  task t_finish;
    int n;
    repeat (2)
    begin
      host(display_ctl_pkg::CMD_START, 4'h0, 16'h0, OK);
      host(display_ctl_pkg::CMD_FINISH, 4'h0, 16'h0, OK);
      rdv = 32'hffffffff;
      for (n = 0; rdv[16] !== 1'b0; n++)
      begin
        if (n == 50) tmo();
        axr(display_ctl_pkg::OFF_STATE);
      end
      chk(32'(rdv[16:0]), 32'h00010);
      host(display_ctl_pkg::CMD_LOAD_IE, 4'h0, 16'heecf, OK);
    end
  endtask
  task t_frame;
    int n;
    axr(display_ctl_pkg::OFF_STATUS);
    chk(rdv, 32'h6);
    axw(display_ctl_pkg::OFF_MASK, 32'h1);
    chk(32'(bds), 32'(display_ctl_pkg::RESP_OKAY));
    host(display_ctl_pkg::CMD_LOAD_P, 4'h0, 16'h0020, OK);
    host(display_ctl_pkg::CMD_START, 4'h0, 16'h0, OK);
    // 19 to 21 ms scale to 190..210 cycles at ten cycles a millisecond
    for (n = 0; hirq !== 1'b1; n++)
    begin
      if (n == 400) tmo();
      @(negedge aclk);
    end
    chk(32'(n inside {[190:210]}), 32'h1);
    @(negedge aclk);
    chk(32'(irq), 32'h1);
    axr(display_ctl_pkg::OFF_STATE);
    chk(32'(rdv[18:0]), 32'h50021);
    axw(display_ctl_pkg::OFF_MASK, 32'h0);
    @(negedge aclk);
    chk(32'(irq), 32'h0);
    host(display_ctl_pkg::CMD_RESET, 4'h0, 16'h0, OK);
    chk(32'(hirq), 32'h0);
    axw(display_ctl_pkg::OFF_MASK, 32'h1);
    @(negedge aclk);
    chk(32'(irq), 32'h1);
    axr(display_ctl_pkg::OFF_STATUS);
    chk(rdv, 32'h3);
    @(negedge aclk);
    chk(32'(irq), 32'h0);
  endtask
  initial
  begin
    error_cnt = 0;
    tests_run = 0;
    aresetn = 1'b0;
    {cv, slow, awv, wv, br, arv, rr} = 7'h0;
    {cc, cr, cw} = 24'h0;
    {awa, ara, wdata} = 48'h0;
    wstrb = 4'hf;
    rdv = 32'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_idle();
    t_run();
    t_finish();
    t_frame();
    report_and_stop();
  end
endmodule // testbench
bind display_control display_ctl_sva sva (.aclk(aclk), .aresetn(aresetn),
  .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_reply(cmd_reply), .cmd_reject(cmd_reject),
  .cmd_rdata(cmd_rdata), .host_irq(host_irq), .mem_req(mem_req), .mem_addr(mem_addr),
  .mem_ack(mem_ack), .mem_data(mem_data));
`default_nettype wire
